// File: design/die_ctrl.sv
// Purpose: Serial register port, bus transmitter control, sleep and wake, analog mux control
// Assumes: ref_clk 20 MHz; serial port mode 0, MSB first, 16-bit frames
// Notes: Pins except cs_to_calibration_pin and watchdog_reset pass two flip-flops before use
// Contract
// - Watchdog reset clears registers except reset cause
// - Sleep turns regulator off, holds reset low
// - Bus or wake pin wake, unmaskable, like power-on
// - Wake sets bus or pin wake flag
// - Transmitter off until power stage enable set
// - Two-bit slew select, reset selects 20 kbit/s
// - Current limit sets flag, later disables transmitter
// - Transmit low drives bus dominant, high recessive
// - Undriven transmit input reads as high; no pull-up here, the transmit synchroniser resets high, as do the select and receive ones
// - Bus wake reported two clocks after edge
// - Four-bit source select picks twelve sources
// - Gain bit sets half-bridge sense scaling
// - Current source enable switches source on/off
// - Reset clears current source enable
// - Current source routable to calibration pin
// - Level field four rising levels, reset 00
// - Gain bit one low, zero high, reset 0
// - Codes 0-3 half-bridges, 4 high-side one
`timescale 1ns/1ps
`include "die_ctrl_regs.svh"
module die_ctrl
  import die_ctrl_pkg::*;
#(
  parameter int LIMIT_CYCLES = `LIMIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_ss_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic tx_data,
  input wire logic bus_rx,
  input wire logic bus_current_limit,
  input wire logic wake_pin_input,
  input wire logic watchdog_reset,
  input wire logic cs_to_calibration_pin,
  output logic bus_out,
  output logic bus_oe_n,
  output logic [1:0] bus_slew_select,
  output logic regulator_enable,
  output logic reset_out_n,
  output mux_ctrl_type analog_mux_output_ctrl,
  output logic cs_to_analog_input,
  output logic cs_to_calibration
);
  initial begin
    if (LIMIT_CYCLES < 1 || LIMIT_CYCLES > 65535) $error("LIMIT_CYCLES out of range");
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] sclk_s, ss_s, mosi_s, tx_s, rx_s, cl_s, wk_s;
  logic sclk_d, ss_d, rx_d;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= 2'b00;
      ss_s <= 2'b11;
      mosi_s <= 2'b00;
      tx_s <= 2'b11;
      rx_s <= 2'b11;
      cl_s <= 2'b00;
      wk_s <= 2'b00;
      sclk_d <= 1'b0;
      ss_d <= 1'b1;
      rx_d <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], spi_sclk};
      ss_s <= {ss_s[0], spi_ss_n};
      mosi_s <= {mosi_s[0], spi_mosi};
      tx_s <= {tx_s[0], tx_data};
      rx_s <= {rx_s[0], bus_rx};
      cl_s <= {cl_s[0], bus_current_limit};
      wk_s <= {wk_s[0], wake_pin_input};
      sclk_d <= sclk_s[1];
      ss_d <= ss_s[1];
      rx_d <= rx_s[1];
    end
  end
  logic sclk_rise, sclk_fall, ss_fall, ss_rise, rx_rise;
  assign sclk_rise = sclk_s[1] & ~sclk_d & ~ss_s[1];
  assign sclk_fall = ~sclk_s[1] & sclk_d & ~ss_s[1];
  assign ss_fall = ~ss_s[1] & ss_d;
  assign ss_rise = ss_s[1] & ~ss_d;
  assign rx_rise = rx_s[1] & ~rx_d;
  ////////////////////////////////////////////////////////////////////////////
  // Registers and serial frame
  logic [7:0] system_control_register_reg, amux_reg, rcause_reg, status_byte, rd_data;
  logic [15:0] shift_reg, frame_reg;
  logic [4:0] bit_cnt_reg;
  logic cl_flag_reg, shutdown_reg, wake_event, clear_regs, write_ok;
  logic [4:0] addr;
  power_state_type state_reg;
  logic [1:0] wake_pipe_reg;
  logic [15:0] limit_cnt_reg;
  assign status_byte = {cl_flag_reg, 7'h00};
  assign addr = shift_reg[5:1];
  always_comb begin
    if (addr == `SYSTEM_CONTROL_REGISTER_OFS) begin
      rd_data = {system_control_register_reg[7], 5'h00, system_control_register_reg[1:0]};
    end else if (addr == `AMUX_OFS) begin
      rd_data = amux_reg;
    end else if (addr == `SYSTEM_STATUS_REGISTER_OFS) begin
      rd_data = status_byte;
    end else if (addr == `RCAUSE_OFS) begin
      rd_data = rcause_reg;
    end else begin
      rd_data = 8'h00;
    end
  end
  // Even parity over read/write flag and address, writes only
  assign write_ok = ss_rise && bit_cnt_reg == 5'h10 && !shift_reg[10] && ^shift_reg[15:9] == 1'b0;
  assign clear_regs = watchdog_reset | wake_event;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 16'h0000;
      frame_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      spi_miso <= 1'b1;
      spi_miso_oe_n <= 1'b1;
    end else if (ss_fall) begin
      bit_cnt_reg <= 5'h00;
      frame_reg <= {status_byte, 8'h00};
      spi_miso <= status_byte[7];
      spi_miso_oe_n <= 1'b0;
    end else if (ss_s[1]) begin
      spi_miso_oe_n <= 1'b1;
    end else if (sclk_rise && bit_cnt_reg < 5'h10) begin
      shift_reg <= {shift_reg[14:0], mosi_s[1]};
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (bit_cnt_reg == 5'h06) begin
        frame_reg[7:0] <= rd_data;
      end
    end else if (sclk_fall && bit_cnt_reg < 5'h10) begin
      spi_miso <= frame_reg[4'(4'hF - bit_cnt_reg[3:0])];
    end
  end
  // System control
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_control_register_reg <= `SYSTEM_CONTROL_REGISTER_RESET;
    end else if (clear_regs) begin
      system_control_register_reg <= `SYSTEM_CONTROL_REGISTER_RESET;
    end else if (write_ok && shift_reg[15:11] == `SYSTEM_CONTROL_REGISTER_OFS) begin
      system_control_register_reg <= shift_reg[7:0];
    end else begin
      system_control_register_reg[`SYSTEM_CONTROL_REGISTER_SLEEP_BIT] <= 1'b0;
    end
  end
  // Analog mux and current source control
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      amux_reg <= `AMUX_RESET;
    end else if (clear_regs) begin
      amux_reg <= `AMUX_RESET;
    end else if (write_ok && shift_reg[15:11] == `AMUX_OFS) begin
      amux_reg <= shift_reg[7:0];
    end
  end
  // Reset cause: survives watchdog, bits cleared by writing one, set wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcause_reg <= `RCAUSE_RESET;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (write_ok && shift_reg[15:11] == `RCAUSE_OFS && shift_reg[i]) begin
          rcause_reg[i] <= 1'b0;
        end
      end
      if (watchdog_reset) begin
        rcause_reg[`RCAUSE_WDR_BIT] <= 1'b1;
      end
      if (wake_event) begin
        rcause_reg[`RCAUSE_POR_BIT] <= 1'b1;
        rcause_reg[`RCAUSE_BUSW_BIT] <= wake_pipe_reg[1];
        rcause_reg[`RCAUSE_PINW_BIT] <= wk_s[1];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Sleep and wake
  assign wake_event = state_reg == WAKE_WAIT && (wake_pipe_reg[1] || wk_s[1]);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RUN;
      wake_pipe_reg <= 2'b00;
    end else begin
      wake_pipe_reg <= {wake_pipe_reg[0], state_reg != RUN && rx_rise};
      case (state_reg)
        RUN: begin
          if (system_control_register_reg[`SYSTEM_CONTROL_REGISTER_SLEEP_BIT] && !watchdog_reset) begin
            state_reg <= SLEEP;
          end
        end
        SLEEP: begin
          state_reg <= WAKE_WAIT;
        end
        WAKE_WAIT: begin
          if (wake_event) begin
            state_reg <= RUN;
          end
        end
        default: begin
          state_reg <= RUN;
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regulator_enable <= 1'b1;
      reset_out_n <= 1'b0;
    end else begin
      regulator_enable <= state_reg == RUN;
      reset_out_n <= state_reg == RUN && !clear_regs;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus transmitter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cl_flag_reg <= 1'b0;
      limit_cnt_reg <= 16'h0000;
      shutdown_reg <= 1'b0;
    end else begin
      cl_flag_reg <= cl_s[1] & ~clear_regs;
      if (!cl_s[1] || clear_regs) begin
        limit_cnt_reg <= 16'h0000;
      end else if (limit_cnt_reg < 16'(LIMIT_CYCLES)) begin
        limit_cnt_reg <= limit_cnt_reg + 16'h0001;
      end
      if (clear_regs || !system_control_register_reg[`SYSTEM_CONTROL_REGISTER_POWER_STAGE_ENABLE_BIT]) begin
        shutdown_reg <= 1'b0;
      end else if (limit_cnt_reg == 16'(LIMIT_CYCLES)) begin
        shutdown_reg <= 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_out <= 1'b0;
      bus_oe_n <= 1'b1;
      bus_slew_select <= `SLEW_20K;
    end else begin
      bus_out <= 1'b0;
      bus_oe_n <= !(system_control_register_reg[`SYSTEM_CONTROL_REGISTER_POWER_STAGE_ENABLE_BIT] && !shutdown_reg && state_reg == RUN &&
                    !tx_s[1]);
      bus_slew_select <= system_control_register_reg[1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Analog mux outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_mux_output_ctrl <= '0;
      cs_to_analog_input <= 1'b0;
      cs_to_calibration <= 1'b0;
    end else begin
      analog_mux_output_ctrl.cs_enable <= amux_reg[`AMUX_CURRENT_SOURCE_ENABLE_BIT];
      analog_mux_output_ctrl.cs_level <= amux_reg[6:5];
      analog_mux_output_ctrl.gain_low <= amux_reg[`AMUX_GAIN_BIT];
      analog_mux_output_ctrl.source <= amux_reg[3:0] < `MUX_SOURCES ? amux_reg[3:0]
                                       : `MUX_IDLE;
      cs_to_analog_input <= amux_reg[`AMUX_CURRENT_SOURCE_ENABLE_BIT] & ~cs_to_calibration_pin;
      cs_to_calibration <= amux_reg[`AMUX_CURRENT_SOURCE_ENABLE_BIT] & cs_to_calibration_pin;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wdog_keeps_cause_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    watchdog_reset && !wake_event |=> amux_reg == 8'h00 && rcause_reg[`RCAUSE_WDR_BIT])
    else $error("watchdog reset handling wrong");
  sleep_outputs_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg != RUN |=> !regulator_enable && !reset_out_n)
    else $error("sleep does not hold regulator and reset");
  bus_wake_delay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == WAKE_WAIT && rx_rise && !wk_s[1] ##1 state_reg == WAKE_WAIT [*1] |=>
    wake_event ##1 rcause_reg[`RCAUSE_BUSW_BIT])
    else $error("bus wake not reported after two clocks");
  wake_clears_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wake_event |=> state_reg == RUN && system_control_register_reg == 8'h00 && amux_reg == 8'h00)
    else $error("wake did not act as power-on");
  tx_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !system_control_register_reg[`SYSTEM_CONTROL_REGISTER_POWER_STAGE_ENABLE_BIT] |=> bus_oe_n)
    else $error("transmitter active without enable");
  tx_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    system_control_register_reg[`SYSTEM_CONTROL_REGISTER_POWER_STAGE_ENABLE_BIT] && !shutdown_reg && state_reg == RUN && !tx_s[1] |=> !bus_oe_n)
    else $error("low transmit input did not drive bus");
  limit_shutdown_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    limit_cnt_reg == 16'(LIMIT_CYCLES) && system_control_register_reg[`SYSTEM_CONTROL_REGISTER_POWER_STAGE_ENABLE_BIT] && !clear_regs |=> shutdown_reg ##1 bus_oe_n)
    else $error("current limit did not shut transmitter");
  mux_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    amux_reg[3:0] >= `MUX_SOURCES && !clear_regs |=> analog_mux_output_ctrl.source == `MUX_IDLE)
    else $error("undefined source code not idle");
  cs_switch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !amux_reg[`AMUX_CURRENT_SOURCE_ENABLE_BIT] |=> !cs_to_analog_input && !cs_to_calibration)
    else $error("current source on while disabled");
endmodule

// File: design/die_ctrl_pkg.sv
// Purpose: Types shared by the die control block
// Assumes: Nothing beyond the register header
// Notes: Types only
package die_ctrl_pkg;
  typedef enum logic [1:0] {
    RUN = 2'b00,
    SLEEP = 2'b01,
    WAKE_WAIT = 2'b10
  } power_state_type;
  typedef struct packed {
    logic cs_enable;
    logic [1:0] cs_level;
    logic gain_low;
    logic [3:0] source;
  } mux_ctrl_type;
endpackage

// File: design/die_ctrl_regs.svh
// Purpose: Offsets, field positions, reset values and timing of the die control block
// Assumes: 8-bit registers on the serial register port
// Notes: Definitions only
`ifndef DIE_CTRL_REGS_SVH
`define DIE_CTRL_REGS_SVH
`define SYSTEM_CONTROL_REGISTER_OFS 5'h00
`define AMUX_OFS 5'h08
`define SYSTEM_STATUS_REGISTER_OFS 5'h0C
`define RCAUSE_OFS 5'h0D
`define SYSTEM_CONTROL_REGISTER_POWER_STAGE_ENABLE_BIT 7
`define SYSTEM_CONTROL_REGISTER_SLEEP_BIT 5
`define SYSTEM_CONTROL_REGISTER_SLEW_LSB 0
`define SYSTEM_CONTROL_REGISTER_RESET 8'h00
`define SLEW_20K 2'h0
`define SLEW_10K 2'h1
`define AMUX_RESET 8'h00
`define AMUX_CURRENT_SOURCE_ENABLE_BIT 7
`define AMUX_LEVEL_LSB 5
`define AMUX_GAIN_BIT 4
`define AMUX_SS_LSB 0
`define MUX_SOURCES 4'hC
`define MUX_IDLE 4'hF
`define SYSTEM_STATUS_REGISTER_CL_BIT 7
`define RCAUSE_POR_BIT 7
`define RCAUSE_WDR_BIT 5
`define RCAUSE_BUSW_BIT 1
`define RCAUSE_PINW_BIT 0
`define RCAUSE_RESET 8'h80
`define CLK_PERIOD_NS 50
`define LIMIT_TIME_NS 20000
`define LIMIT_CYCLES (`LIMIT_TIME_NS / `CLK_PERIOD_NS)
`define WAKE_REPORT_CYCLES 2
`endif

// File: tb/analog_die_link_and_mux_control_bench.sv
// Purpose: Self-checking bench of the die control block
// Assumes: Host model drives the serial port; short current limit count
// Notes: Reset checks, table of mux cases, then hand-written cases
`timescale 1ns/1ps
`include "die_ctrl_regs.svh"
module analog_die_link_and_mux_control_bench;
  import die_ctrl_pkg::*;
  typedef struct packed {
    logic cal;
    logic [7:0] wr;
    mux_ctrl_type mux;
    logic to_in;
    logic to_cal;
  } row_type;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic spi_sclk, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe_n, tx_data, bus_out, bus_oe_n;
  logic bus_rx = 1'b1;
  logic bus_current_limit = 1'b0;
  logic wake_pin_input = 1'b0;
  logic watchdog_reset = 1'b0;
  logic cs_to_calibration_pin = 1'b0;
  logic regulator_enable, reset_out_n, cs_to_analog_input, cs_to_calibration;
  logic [1:0] bus_slew_select;
  mux_ctrl_type analog_mux_output_ctrl;
  logic [15:0] rx;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  row_type rows [6] = '{
    '{1'b0, 8'h00, 8'h00, 1'b0, 1'b0},
    '{1'b0, 8'h04, 8'h04, 1'b0, 1'b0},
    '{1'b0, 8'h93, 8'h93, 1'b1, 1'b0},
    '{1'b1, 8'hEB, 8'hEB, 1'b0, 1'b1},
    '{1'b0, 8'hA9, 8'hA9, 1'b1, 1'b0},
    '{1'b0, 8'h4C, 8'h4F, 1'b0, 1'b0}};
  always #25 ref_clk = ~ref_clk;
  die_host host_u (.ref_clk(ref_clk), .spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .tx_data(tx_data));
  die_ctrl #(.LIMIT_CYCLES(8)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .spi_sclk(spi_sclk),
    .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
    .tx_data(tx_data), .bus_rx(bus_rx), .bus_current_limit(bus_current_limit),
    .wake_pin_input(wake_pin_input), .watchdog_reset(watchdog_reset),
    .cs_to_calibration_pin(cs_to_calibration_pin), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
    .bus_slew_select(bus_slew_select), .regulator_enable(regulator_enable), .reset_out_n(reset_out_n),
    .analog_mux_output_ctrl(analog_mux_output_ctrl), .cs_to_analog_input(cs_to_analog_input),
    .cs_to_calibration(cs_to_calibration));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_wake();
    for (int k = 0; k < 40 && regulator_enable !== 1'b1; k++) @(negedge ref_clk);
    repeat (6) @(negedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    host_u.xfer(`AMUX_OFS, 1'b1, 8'h00, rx);
    chk("mux reset", 16'h0000, {8'h00, rx[7:0]});
    host_u.xfer(`RCAUSE_OFS, 1'b1, 8'h00, rx);
    chk("cause reset", 16'h0080, {8'h00, rx[7:0]});
    chk("slew reset", 16'h0000, {14'h0000, bus_slew_select});
    chk("bus idle", 16'h0001, {15'h0000, bus_oe_n});
    chk("bus out low", 16'h0000, {15'h0000, bus_out});
    chk("miso released", 16'h0001, {15'h0000, spi_miso_oe_n});
    $display("test reset done");
    foreach (rows[i]) begin
      cs_to_calibration_pin = rows[i].cal;
      host_u.xfer(`AMUX_OFS, 1'b0, rows[i].wr, rx);
      host_u.xfer(`AMUX_OFS, 1'b1, 8'h00, rx);
      chk("mux readback", {8'h00, rows[i].wr}, {8'h00, rx[7:0]});
      chk("mux ctrl", {8'h00, rows[i].mux}, {8'h00, analog_mux_output_ctrl});
      chk("cs route", {14'h0000, rows[i].to_in, rows[i].to_cal},
        {14'h0000, cs_to_analog_input, cs_to_calibration});
    end
    cs_to_calibration_pin = 1'b0;
    $display("test mux table done");
    host_u.tx_data = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk("tx without power", 16'h0001, {15'h0000, bus_oe_n});
    for (int s = 0; s < 4; s++) begin
      host_u.xfer(`SYSTEM_CONTROL_REGISTER_OFS, 1'b0, 8'h80 | 8'(s), rx);
      chk("slew", 16'(s), {14'h0000, bus_slew_select});
    end
    chk("tx dominant", 16'h0000, {15'h0000, bus_oe_n});
    bus_current_limit = 1'b1;
    host_u.xfer(`SYSTEM_STATUS_REGISTER_OFS, 1'b1, 8'h00, rx);
    chk("limit flag", 16'h0001, {15'h0000, rx[15]});
    chk("limit shutdown", 16'h0001, {15'h0000, bus_oe_n});
    bus_current_limit = 1'b0;
    host_u.xfer(`SYSTEM_CONTROL_REGISTER_OFS, 1'b0, 8'h00, rx);
    host_u.xfer(`SYSTEM_CONTROL_REGISTER_OFS, 1'b0, 8'h80, rx);
    chk("re-enable", 16'h0000, {15'h0000, bus_oe_n});
    host_u.tx_data = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("tx recessive", 16'h0001, {15'h0000, bus_oe_n});
    $display("test transmitter done");
    host_u.xfer(`AMUX_OFS, 1'b0, 8'hAA, rx);
    host_u.xfer(`SYSTEM_CONTROL_REGISTER_OFS, 1'b0, 8'h81, rx);
    watchdog_reset = 1'b1;
    @(negedge ref_clk);
    watchdog_reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    host_u.xfer(`AMUX_OFS, 1'b1, 8'h00, rx);
    chk("wd mux", 16'h0000, {8'h00, rx[7:0]});
    chk("wd slew", 16'h0000, {14'h0000, bus_slew_select});
    host_u.xfer(`RCAUSE_OFS, 1'b1, 8'h00, rx);
    chk("wd cause", 16'h00A0, {8'h00, rx[7:0]});
    $display("test watchdog done");
    host_u.xfer(`RCAUSE_OFS, 1'b0, 8'hFF, rx);
    bus_rx = 1'b0;
    host_u.xfer(`SYSTEM_CONTROL_REGISTER_OFS, 1'b0, 8'h20, rx);
    chk("sleep power", 16'h0000, {14'h0000, regulator_enable, reset_out_n});
    bus_rx = 1'b1;
    wait_wake();
    chk("bus wake", 16'h0003, {14'h0000, regulator_enable, reset_out_n});
    host_u.xfer(`RCAUSE_OFS, 1'b1, 8'h00, rx);
    chk("bus wake cause", 16'h0082, {8'h00, rx[7:0]});
    host_u.xfer(`RCAUSE_OFS, 1'b0, 8'hFF, rx);
    host_u.xfer(`AMUX_OFS, 1'b0, 8'h55, rx);
    host_u.xfer(`SYSTEM_CONTROL_REGISTER_OFS, 1'b0, 8'h20, rx);
    chk("sleep power 2", 16'h0000, {14'h0000, regulator_enable, reset_out_n});
    wake_pin_input = 1'b1;
    wait_wake();
    wake_pin_input = 1'b0;
    host_u.xfer(`RCAUSE_OFS, 1'b1, 8'h00, rx);
    chk("pin wake cause", 16'h0081, {8'h00, rx[7:0]});
    host_u.xfer(`AMUX_OFS, 1'b1, 8'h00, rx);
    chk("wake clears mux", 16'h0000, {8'h00, rx[7:0]});
    $display("test sleep done");
    finish_test();
  end
endmodule

// File: tb/die_host.sv
// Purpose: Host model: serial register port master and transmit line
// Assumes: Mode 0, MSB first, 16-bit frames, parity even over read flag and address
// Notes: Drives on the falling edge of ref_clk; HALF sets sclk phase length
`timescale 1ns/1ps
module die_host #(
  parameter int HALF = 4
) (
  input wire logic ref_clk,
  output logic spi_sclk,
  output logic spi_ss_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  output logic tx_data
);
  initial begin
    spi_sclk = 1'b0;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
    tx_data = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One frame; rx holds status byte then register byte
  task automatic xfer(input logic [4:0] adr, input logic rd, input logic [7:0] dat, output logic [15:0] rx);
    logic [15:0] frm;
    frm = {adr, rd, ^{rd, adr}, 1'b0, dat};
    @(negedge ref_clk);
    spi_ss_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = frm[i];
      repeat (HALF) @(negedge ref_clk);
      rx[i] = spi_miso;
      spi_sclk = 1'b1;
      repeat (HALF) @(negedge ref_clk);
      spi_sclk = 1'b0;
    end
    repeat (HALF) @(negedge ref_clk);
    spi_ss_n = 1'b1;
    // Released line shows no stale value
    spi_mosi = ~spi_mosi;
    repeat (8) @(negedge ref_clk);
  endtask
endmodule
